// ---- mord_defs.svh ----
// Purpose: constants of the multiply-accumulate opcode range decoder
// Assumes: included by its bare name after the package
// Notes:   offsets are byte addresses on the register bus
`ifndef MORD_DEFS_SVH
`define MORD_DEFS_SVH

// opcode prefix bits 31:25 and option field bits 24:21
`define MORD_PFX_MSB     31
`define MORD_PFX_LSB     25
`define MORD_PFX         7'h60
`define MORD_MMOD_MSB    24
`define MORD_MMOD_LSB    21
`define MORD_MMOD_IS     4'h8
`define MORD_MMOD_SCALED_SIGNED_INTEGER_OPTION   4'h9
`define MORD_MMOD_IH     4'hB
`define MORD_IH_LAST     32'hC165_D9FF

// field positions
`define MORD_B_MIX       20
`define MORD_B_FULL      19
`define MORD_B_W1        18
`define MORD_OP1_MSB     17
`define MORD_OP1_LSB     16
`define MORD_B_H01       15
`define MORD_B_H11       14
`define MORD_B_W0        13
`define MORD_OP0_MSB     12
`define MORD_OP0_LSB     11
`define MORD_B_H00       10
`define MORD_B_H10       9
`define MORD_DST_MSB     8
`define MORD_DST_LSB     6
`define MORD_SRC0_MSB    5
`define MORD_SRC0_LSB    3
`define MORD_SRC1_MSB    2
`define MORD_SRC1_LSB    0

// register map and reset values
`define MORD_ADR_CTRL    8'h00
`define MORD_ADR_STAT    8'h04
`define MORD_ADR_LAST    8'h08
`define MORD_ADR_CTL     8'h0C
`define MORD_CTRL_RST    1'h1
`define MORD_CNT_RST     16'h0000

`endif

// ---- mord_pkg.sv ----
// Purpose: types of the multiply-accumulate opcode range decoder
// Assumes: nothing
// Notes:   accumulator op codes equal the raw two-bit opcode field
`default_nettype none
package mord_pkg;

  typedef enum logic [1:0] {
    MORD_ACC_LOAD = 2'h0,
    MORD_ACC_ADD  = 2'h1,
    MORD_ACC_SUB  = 2'h2,
    MORD_ACC_IDLE = 2'h3
  } mord_acc_op_t;

  typedef enum logic [1:0] {
    MORD_OPT_NONE   = 2'h0,
    MORD_OPT_INT    = 2'h1,
    MORD_OPT_SCALED = 2'h2,
    MORD_OPT_HIGH   = 2'h3
  } mord_opt_t;

  typedef struct packed {
    mord_opt_t    opt;      // arithmetic option
    logic         mixed;    // mixed-operand flag
    logic         full;     // full data register destination
    mord_acc_op_t a0_op;    // accumulator_zero operation
    logic         a0_mul;   // accumulator_zero takes a product
    logic         a0_wr;    // accumulator_zero result written back
    mord_acc_op_t a1_op;    // accumulator_one operation
    logic         a1_mul;   // accumulator_one takes a product
    logic         a1_wr;    // accumulator_one result written back
    logic [3:0]   half_sel; // source_half_operand selects
    logic [2:0]   dst;      // destination register number
    logic [2:0]   src0;     // first source register
    logic [2:0]   src1;     // second source register
  } mord_ctl_t;

endpackage : mord_pkg
`default_nettype wire

// ---- mord_field_dec.sv ----
// Purpose: combinational field decode of one mac opcode word
// Assumes: word is stable for the cycle it is sampled
// Notes:   two single-accumulator full-register families override
//          the plain field view
`timescale 1ns/1ps
`default_nettype none
`include "mord_defs.svh"
module mord_field_dec
  import mord_pkg::*;
(
  input  wire logic [31:0] i_instr,    // opcode word
  output var  mord_ctl_t   o_ctl,      // decoded controls
  output var  logic        o_in_slice  // word lies in this slice
);

  function automatic logic takes_mul(input logic [1:0] code);
    return code != MORD_ACC_IDLE;
  endfunction : takes_mul

  function automatic mord_opt_t opt_of(input logic [3:0] mmod);
    return (mmod == `MORD_MMOD_IS)   ? MORD_OPT_INT :
           (mmod == `MORD_MMOD_SCALED_SIGNED_INTEGER_OPTION) ? MORD_OPT_SCALED :
           (mmod == `MORD_MMOD_IH)   ? MORD_OPT_HIGH : MORD_OPT_NONE;
  endfunction : opt_of

  wire logic [3:0] mmod = i_instr[`MORD_MMOD_MSB:`MORD_MMOD_LSB];
  wire logic       full = i_instr[`MORD_B_FULL];
  wire logic       w0   = i_instr[`MORD_B_W0];
  wire logic       w1   = i_instr[`MORD_B_W1];
  wire logic [1:0] op0  = i_instr[`MORD_OP0_MSB:`MORD_OP0_LSB];
  wire logic [1:0] op1  = i_instr[`MORD_OP1_MSB:`MORD_OP1_LSB];
  wire mord_opt_t  opt  = opt_of(mmod);

  // high-half option only partly belongs here
  wire logic ih_ok = (opt != MORD_OPT_HIGH) |
                     (i_instr <= `MORD_IH_LAST);
  wire logic pfx_ok = i_instr[`MORD_PFX_MSB:`MORD_PFX_LSB] == `MORD_PFX;

  // single accumulator_one to odd register
  wire logic odd_single = full & ~w1 & takes_mul(op1) & ~w0 &
                          ~takes_mul(op0);
  // single accumulator_zero to even register beats dual view
  wire logic even_single = full & w1 & (op1 == 2'h1) &
                           (i_instr[15:13] == 3'h0) &
                           takes_mul(op0);

  wire mord_acc_op_t a1_op = even_single ? MORD_ACC_IDLE
                                         : mord_acc_op_t'(op1);

  assign o_in_slice     = pfx_ok & (opt != MORD_OPT_NONE) & ih_ok;
  assign o_ctl.opt      = opt;
  assign o_ctl.mixed    = i_instr[`MORD_B_MIX];
  assign o_ctl.full     = full;
  assign o_ctl.a0_op    = mord_acc_op_t'(op0);
  assign o_ctl.a0_mul   = takes_mul(op0);
  assign o_ctl.a0_wr    = w0 | even_single;
  assign o_ctl.a1_op    = a1_op;
  assign o_ctl.a1_mul   = takes_mul(a1_op);
  assign o_ctl.a1_wr    = (w1 & ~even_single) | odd_single;
  assign o_ctl.half_sel = {i_instr[`MORD_B_H00], i_instr[`MORD_B_H10],
                           i_instr[`MORD_B_H01], i_instr[`MORD_B_H11]};
  assign o_ctl.dst  = i_instr[`MORD_DST_MSB:`MORD_DST_LSB];
  assign o_ctl.src0 = i_instr[`MORD_SRC0_MSB:`MORD_SRC0_LSB];
  assign o_ctl.src1 = i_instr[`MORD_SRC1_MSB:`MORD_SRC1_LSB];

endmodule : mord_field_dec
`default_nettype wire

// ---- mord_decoder.sv ----
// Purpose: mac opcode range decoder with wishbone status registers
// Assumes: opcode words come from logic on i_clk, no synchroniser
// Notes:   one cycle from opcode to registered controls
`timescale 1ns/1ps
`default_nettype none
`include "mord_defs.svh"
module mord_decoder
  import mord_pkg::*;
(
  input  wire logic        i_clk,         // core clock, 125 MHz
  input  wire logic        i_rst_n,       // async reset, active low
  input  wire logic        i_instr_valid, // opcode word present
  input  wire logic [31:0] i_instr,       // opcode word
  output var  logic        o_ctl_valid,   // controls valid pulse
  output var  mord_ctl_t   o_ctl,         // datapath controls
  output var  logic        o_unsupported, // word outside slice pulse
  input  wire logic        i_wb_cyc,      // wishbone cycle
  input  wire logic        i_wb_stb,      // wishbone strobe
  input  wire logic        i_wb_we,       // wishbone write
  input  wire logic [7:0]  i_wb_adr,      // wishbone byte address
  input  wire logic [3:0]  i_wb_sel,      // wishbone byte enables
  input  wire logic [31:0] i_wb_dat,      // wishbone write data
  output var  logic [31:0] o_wb_dat,      // wishbone read data
  output var  logic        o_wb_ack       // wishbone acknowledge
);

  ////////////////////////////////////////////////////////////////////
  // decode

  mord_ctl_t dec_ctl;
  logic      dec_in_slice;

  mord_field_dec u_dec (
    .i_instr    (i_instr),
    .o_ctl      (dec_ctl),
    .o_in_slice (dec_in_slice)
  );

  logic        en_reg;
  logic        ctl_valid_reg;
  mord_ctl_t   ctl_reg;
  logic        unsup_reg;
  logic [31:0] last_reg;
  logic [15:0] cnt_ok_reg;
  logic [15:0] cnt_bad_reg;
  logic [15:0] cnt_ok_next;
  logic [15:0] cnt_bad_next;

  // disabled decoder drops words silently
  wire logic go      = i_instr_valid & en_reg;
  wire logic take_ok = go & dec_in_slice;
  wire logic take_bad = go & ~dec_in_slice;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl_valid_reg <= 1'h0;
      unsup_reg     <= 1'h0;
      ctl_reg       <= '0;
      last_reg      <= 32'h0000_0000;
    end else begin
      ctl_valid_reg <= take_ok;
      unsup_reg     <= take_bad;
      if (take_ok) begin
        ctl_reg  <= dec_ctl;
        last_reg <= i_instr;
      end
    end
  end

  assign o_ctl_valid   = ctl_valid_reg;
  assign o_ctl         = ctl_reg;
  assign o_unsupported = unsup_reg;

  ////////////////////////////////////////////////////////////////////
  // wishbone slave

  logic        ack_reg;
  logic [31:0] rd_reg;

  wire logic wb_req  = i_wb_cyc & i_wb_stb & ~ack_reg;
  wire logic wb_wr   = wb_req & i_wb_we;
  wire logic hit_ctrl = i_wb_adr == `MORD_ADR_CTRL;
  wire logic hit_stat = i_wb_adr == `MORD_ADR_STAT;
  wire logic hit_last = i_wb_adr == `MORD_ADR_LAST;
  wire logic hit_ctl  = i_wb_adr == `MORD_ADR_CTL;
  wire logic wr_en   = wb_wr & hit_ctrl & i_wb_sel[0];
  wire logic clr_cnt = wb_wr & hit_stat & (|i_wb_sel);

  wire logic [31:0] rd_mux =
    hit_ctrl ? {31'h0000_0000, en_reg} :
    hit_stat ? {cnt_bad_reg, cnt_ok_reg} :
    hit_last ? last_reg :
    hit_ctl  ? {7'h00, ctl_reg} : 32'h0000_0000;

  // an event in the clearing cycle still counts
  assign cnt_ok_next  = (clr_cnt ? `MORD_CNT_RST : cnt_ok_reg) +
                        {15'h0000, take_ok};
  assign cnt_bad_next = (clr_cnt ? `MORD_CNT_RST : cnt_bad_reg) +
                        {15'h0000, take_bad};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_reg <= 1'h0;
      rd_reg  <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_req;
      rd_reg  <= (wb_req & ~i_wb_we) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_reg      <= `MORD_CTRL_RST;
      cnt_ok_reg  <= `MORD_CNT_RST;
      cnt_bad_reg <= `MORD_CNT_RST;
    end else begin
      if (wr_en) begin
        en_reg <= i_wb_dat[0];
      end
      cnt_ok_reg  <= cnt_ok_next;
      cnt_bad_reg <= cnt_bad_next;
    end
  end

  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rd_reg;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  wire logic [1:0] in_op0 = i_instr[12:11];
  wire logic [1:0] in_op1 = i_instr[17:16];

  half_lo_op_a: assert property (
    go && i_instr inside {[32'hC103_2000:32'hC103_37FF]}
    |=> o_ctl_valid && o_ctl.a0_wr && !o_ctl.full && !o_ctl.a1_wr
        && o_ctl.a0_op == mord_acc_op_t'($past(in_op0))
        && o_ctl.opt == MORD_OPT_INT)
    else $error("low half accumulator_zero decode wrong");

  pair_move_a: assert property (
    go && i_instr inside {[32'hC107_3800:32'hC107_39C0]}
    |=> o_ctl.a0_wr && o_ctl.a1_wr && !o_ctl.a0_mul
        && !o_ctl.a1_mul && !o_ctl.full)
    else $error("paired transfer decode wrong");

  scaled_move_a: assert property (
    go && i_instr inside {[32'hC127_3800:32'hC127_39C0]}
    |=> o_ctl.a0_wr && o_ctl.a1_wr && !o_ctl.a0_mul
        && o_ctl.opt == MORD_OPT_SCALED)
    else $error("scaled paired transfer decode wrong");

  a1_half_a: assert property (
    go && (i_instr & 32'hFFEC_3800) == 32'hC104_1800
    && in_op1 != 2'h3
    |=> o_ctl.a1_wr && !o_ctl.a0_wr && !o_ctl.full
        && o_ctl.a1_mul && !o_ctl.a0_mul
        && o_ctl.a1_op == mord_acc_op_t'($past(in_op1)))
    else $error("accumulator_one half decode wrong");

  dual_half_a: assert property (
    go && i_instr inside {[32'hC104_2000:32'hC107_FFFF]} && i_instr[13]
    |=> o_ctl.a0_wr && o_ctl.a1_wr && !o_ctl.full)
    else $error("dual half decode wrong");

  a0_silent_a: assert property (
    go && i_instr inside {[32'hC104_0000:32'hC107_DFFF]}
    && !i_instr[13]
    |=> !o_ctl.a0_wr && o_ctl.a1_wr && !o_ctl.full)
    else $error("silent accumulator_zero decode wrong");

  odd_single_a: assert property (
    go && (i_instr & 32'hFFCC_3800) == 32'hC108_1800
    && in_op1 != 2'h3
    |=> o_ctl.a1_wr && o_ctl.full && !o_ctl.a0_wr
        && !o_ctl.a0_mul && o_ctl.a1_mul)
    else $error("odd register single decode wrong");

  even_single_a: assert property (
    go && (i_instr & 32'hFFDF_F800) inside
      {32'hC10D_0000, 32'hC10D_0800, 32'hC10D_1000}
    |=> o_ctl.a0_wr && o_ctl.full && !o_ctl.a1_wr
        && o_ctl.a1_op == MORD_ACC_IDLE
        && o_ctl.a0_op == mord_acc_op_t'($past(in_op0)))
    else $error("even register single decode wrong");

  dual_full_a: assert property (
    go && i_instr inside {[32'hC10C_2000:32'hC10F_FFFF]} && i_instr[13]
    |=> o_ctl.a0_wr && o_ctl.a1_wr && o_ctl.full)
    else $error("dual full decode wrong");

  even_only_a: assert property (
    go && i_instr inside {[32'hC108_2000:32'hC10B_FFFF]} && i_instr[13]
    |=> o_ctl.a0_wr && !o_ctl.a1_wr && o_ctl.full)
    else $error("even only decode wrong");

  opt_map_a: assert property (
    take_ok
    |=> o_ctl.opt != MORD_OPT_NONE
        && o_ctl.mixed == $past(i_instr[20])
        && (o_ctl.opt == MORD_OPT_SCALED)
           == ($past(i_instr[22:21]) == 2'h1))
    else $error("option map wrong");

  high_opt_a: assert property (
    go && i_instr inside {[32'hC163_2000:32'hC165_D9FF]}
    |=> o_ctl_valid && o_ctl.opt == MORD_OPT_HIGH)
    else $error("high-half option decode wrong");

  high_end_a: assert property (
    go && i_instr inside {[32'hC165_DA00:32'hC17F_FFFF]}
    |=> o_unsupported && !o_ctl_valid)
    else $error("word past slice accepted");

  // masks or ranges pin each single family; random words also land in them
  high_lo_a: assert property (
    go && i_instr inside {[32'hC163_2000:32'hC163_37FF]}
    |=> o_ctl_valid && o_ctl.a0_wr && !o_ctl.a1_wr && !o_ctl.full
        && o_ctl.a0_op == mord_acc_op_t'($past(in_op0))
        && o_ctl.opt == MORD_OPT_HIGH)
    else $error("high-half low half decode wrong");

  high_a1_a: assert property (
    go && (i_instr & 32'hFFFE_3800) == 32'hC164_1800
    && i_instr <= `MORD_IH_LAST
    |=> o_ctl_valid && o_ctl.a1_wr && !o_ctl.a0_wr && !o_ctl.full
        && o_ctl.a1_op == mord_acc_op_t'($past(in_op1))
        && o_ctl.opt == MORD_OPT_HIGH)
    else $error("high-half accumulator_one decode wrong");

  mixed_odd_a: assert property (
    go && (i_instr & 32'hFFFC_3800) == 32'hC118_1800
    && in_op1 != 2'h3
    |=> o_ctl.a1_wr && !o_ctl.a0_wr && o_ctl.full && o_ctl.mixed
        && o_ctl.opt == MORD_OPT_INT)
    else $error("mixed odd register decode wrong");

  scaled_lo_a: assert property (
    go && i_instr inside {[32'hC123_2000:32'hC123_37FF]}
    |=> o_ctl.a0_wr && !o_ctl.a1_wr && !o_ctl.full
        && o_ctl.a0_op == mord_acc_op_t'($past(in_op0))
        && o_ctl.opt == MORD_OPT_SCALED)
    else $error("scaled low half decode wrong");

  scaled_hi_a: assert property (
    go && (i_instr & 32'hFFFC_3800) == 32'hC124_1800
    && in_op1 != 2'h3
    |=> o_ctl.a1_wr && !o_ctl.a0_wr && !o_ctl.full && !o_ctl.mixed
        && o_ctl.opt == MORD_OPT_SCALED)
    else $error("scaled high half decode wrong");

  scaled_even_a: assert property (
    go && (i_instr & 32'hFFFF_F800) inside
      {32'hC12D_0000, 32'hC12D_0800, 32'hC12D_1000}
    |=> o_ctl.a0_wr && !o_ctl.a1_wr && o_ctl.full
        && o_ctl.a0_op == mord_acc_op_t'($past(in_op0))
        && o_ctl.opt == MORD_OPT_SCALED)
    else $error("scaled even register decode wrong");

  scaled_odd_a: assert property (
    go && (i_instr & 32'hFFFC_3800) == 32'hC128_1800
    && in_op1 != 2'h3
    |=> o_ctl.a1_wr && !o_ctl.a0_wr && o_ctl.full && !o_ctl.mixed
        && o_ctl.opt == MORD_OPT_SCALED)
    else $error("scaled odd register decode wrong");

  smix_half_a: assert property (
    go && (i_instr & 32'hFFFC_3800) == 32'hC134_1800
    && in_op1 != 2'h3
    |=> o_ctl.a1_wr && !o_ctl.a0_wr && !o_ctl.full && o_ctl.mixed
        && o_ctl.opt == MORD_OPT_SCALED)
    else $error("scaled mixed high half decode wrong");

  smix_odd_a: assert property (
    go && (i_instr & 32'hFFFC_3800) == 32'hC138_1800
    && in_op1 != 2'h3
    |=> o_ctl.a1_wr && !o_ctl.a0_wr && o_ctl.full && o_ctl.mixed
        && o_ctl.opt == MORD_OPT_SCALED)
    else $error("scaled mixed odd register decode wrong");

  field_route_a: assert property (
    take_ok
    |=> o_ctl.dst == $past(i_instr[8:6])
        && o_ctl.src0 == $past(i_instr[5:3])
        && o_ctl.src1 == $past(i_instr[2:0]))
    else $error("register fields misrouted");

  nest_same_a: assert property (
    take_ok && !i_instr[19] && i_instr[18] && i_instr[13:11] == 3'h3
    |=> o_ctl.a0_op == MORD_ACC_IDLE && !o_ctl.a0_mul && !o_ctl.a0_wr
        && o_ctl.a1_wr)
    else $error("nested encoding controls differ");

  hold_off_a: assert property (
    !en_reg |=> !o_ctl_valid && !o_unsupported)
    else $error("disabled decoder produced output");

  wb_ack_a: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
    else $error("wishbone ack not single cycle");

  count_up_a: assert property (
    take_ok && !clr_cnt |=> cnt_ok_reg == $past(cnt_ok_reg) + 16'h0001)
    else $error("decoded count did not advance");

  dual_cov_c: cover property (
    take_ok ##1 o_ctl.a0_wr && o_ctl.a1_wr && o_ctl.full);
  move_cov_c: cover property (
    take_ok ##1 o_ctl.a0_wr && !o_ctl.a0_mul);
  reject_cov_c: cover property (take_bad ##1 o_unsupported);
  wb_cov_c: cover property (wr_en ##1 o_wb_ack);
  smix_cov_c: cover property (
    take_ok ##1 o_ctl.opt == MORD_OPT_SCALED && o_ctl.mixed);

endmodule : mord_decoder
`default_nettype wire

// ---- mord_fetch_model.sv ----
// Purpose: opcode word source standing in for fetch and sequencer logic
// Assumes: words are launched just after a rising edge of i_clk
// Notes:   each idle cycle inverts the bus word with o_valid low, so two idle cycles show the last word again
`timescale 1ns/1ps
`default_nettype none
module mord_fetch_model (
  input  wire logic        i_clk,   // core clock
  output var  logic        o_valid, // opcode word present
  output var  logic [31:0] o_instr  // opcode word
);
  initial begin
    o_valid = 1'b0;
    o_instr = 32'h0000_0000;
  end

  // idle cycles toggle the word so a stale value never looks valid
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_valid <= 1'b0;
      o_instr <= ~o_instr;
    end
  endtask : idle

  task automatic send(input logic [31:0] w, input int gap);
    idle(gap);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_instr <= w;
  endtask : send
endmodule : mord_fetch_model
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: self-checking bench of the mac opcode range decoder
// Assumes: controls follow one cycle after each taken word
// Notes:   expectations come from the opcode field view
`timescale 1ns/1ps
`default_nettype none
`include "mord_defs.svh"
module tb_top import mord_pkg::*;;
  typedef struct packed {
    logic      unsup;
    mord_ctl_t c;
  } mord_exp_t;

  logic        i_clk, i_rst_n, o_ctl_valid, o_unsupported, f_valid;
  logic        cyc, stb, we_r, o_wb_ack, en;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, o_wb_dat, f_instr, last_w, rnd;
  logic [15:0] n_ok, n_un;
  mord_ctl_t   o_ctl, last_c;
  mord_exp_t   exp_q [$];
  mord_exp_t   e;
  logic [32:0] wb_q [$];
  logic [32:0] r;
  int          bad_count, check_count;
  logic [3:0]  mm [3] = '{4'h8, 4'h9, 4'hB};

  mord_fetch_model u_mord_fetch_model (
    .i_clk(i_clk), .o_valid(f_valid), .o_instr(f_instr));
  mord_decoder u_mord_decoder (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_instr_valid(f_valid),
    .i_instr(f_instr), .o_ctl_valid(o_ctl_valid), .o_ctl(o_ctl),
    .o_unsupported(o_unsupported), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we_r), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task automatic chk_dec(input mord_exp_t x);
    chk("unsupported", x.unsup, o_unsupported);
    if (!x.unsup) chk("ctl", x.c, o_ctl);
  endtask : chk_dec

  function automatic mord_ctl_t exp_ctl(input logic [31:0] w);
    mord_ctl_t c;
    c.opt = (w[24:21] == 4'h8) ? MORD_OPT_INT :
            (w[24:21] == 4'h9) ? MORD_OPT_SCALED : MORD_OPT_HIGH;
    c.mixed = w[20];
    c.full = w[19];
    c.a1_op = mord_acc_op_t'(w[17:16]);
    c.a1_mul = (w[17:16] != 2'h3);
    c.a1_wr = w[18];
    c.a0_op = mord_acc_op_t'(w[12:11]);
    c.a0_mul = (w[12:11] != 2'h3);
    c.a0_wr = w[13];
    c.half_sel = {w[10], w[9], w[15], w[14]};
    c.dst = w[8:6];
    c.src0 = w[5:3];
    c.src1 = w[2:0];
    // odd register family: single accumulator_one result written
    if (w[19] && !w[18] && w[17:16] != 2'h3 && !w[13] && w[12:11] == 2'h3)
      c.a1_wr = 1'b1;
    // even register family wins over the enclosing dual range
    if (w[19] && w[18] && w[17:16] == 2'h1 && w[15:13] == 3'h0 &&
        w[12:11] != 2'h3) begin
      c.a1_op = MORD_ACC_IDLE;
      c.a1_mul = 1'b0;
      c.a1_wr = 1'b0;
      c.a0_wr = 1'b1;
    end
    return c;
  endfunction : exp_ctl

  task automatic put(input logic [31:0] w, input int gap);
    logic ok;
    ok = (w[31:25] == `MORD_PFX) && (w[24:21] == 4'h8 || w[24:21] == 4'h9
         || (w[24:21] == 4'hB && w <= `MORD_IH_LAST));
    if (en) begin
      exp_q.push_back({!ok, exp_ctl(w)});
      if (ok) begin
        n_ok++;
        last_w = w;
        last_c = exp_ctl(w);
      end else n_un++;
    end
    u_mord_fetch_model.send(w, gap);
  endtask : put

  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, input logic [31:0] x);
    int k;
    wb_q.push_back({!w, x});
    @(posedge i_clk);
    {cyc, stb, we_r, adr, sel, dat} <= {2'b11, w, a, s, d};
    for (k = 0; k < 50 && o_wb_ack !== 1'b1; k++) @(posedge i_clk);
    if (k == 50) begin
      bad_count++;
      conclude();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic drain(input string n);
    u_mord_fetch_model.idle(4);
    chk("pending", 0, exp_q.size());
    $display("test %s done", n);
  endtask : drain

  always @(negedge i_clk)
    if (i_rst_n && (o_ctl_valid === 1'b1 || o_unsupported === 1'b1)) begin
      if (exp_q.size() == 0) chk("extra result", 0, 1);
      else begin
        e = exp_q.pop_front();
        chk_dec(e);
      end
    end

  always @(negedge i_clk)
    if (o_wb_ack === 1'b1) begin
      if (wb_q.size() == 0) chk("extra ack", 0, 1);
      else begin
        r = wb_q.pop_front();
        if (r[32]) chk("wb_dat", r[31:0], o_wb_dat);
      end
    end

  logic [31:0] tbl [$] = '{
    32'hC103_2000, 32'hC103_2800, 32'hC103_37FF,
    32'hC107_3800, 32'hC107_39C0,
    32'hC104_1800, 32'hC105_1800, 32'hC106_D9FF,
    32'hC104_2000, 32'hC107_FFFF, 32'hC104_0000, 32'hC107_DFFF,
    32'hC108_1800, 32'hC109_1800, 32'hC10A_D9FF,
    32'hC10D_0000, 32'hC10D_0800, 32'hC10D_17FF,
    32'hC10C_2000, 32'hC10F_FFFF, 32'hC108_2000, 32'hC10B_FFFF,
    32'hC114_1800, 32'hC115_1800, 32'hC116_1800,
    32'hC118_1800, 32'hC119_1800, 32'hC11A_1800,
    32'hC123_2000, 32'hC123_2800, 32'hC123_3000,
    32'hC124_1800, 32'hC125_1800, 32'hC126_1800, 32'hC127_3800,
    32'hC12D_0000, 32'hC12D_0800, 32'hC12D_1000,
    32'hC128_1800, 32'hC129_1800, 32'hC12A_1800,
    32'hC134_1800, 32'hC135_1800, 32'hC136_1800,
    32'hC138_1800, 32'hC139_1800, 32'hC13A_1800,
    32'hC163_2000, 32'hC163_2800, 32'hC163_3000,
    32'hC164_1800, 32'hC165_1800, 32'hC165_D9FF,
    32'hC165_DA00, 32'hC083_1800, 32'hC200_2000};

  initial begin
    {i_rst_n, cyc, stb, we_r, adr, sel, dat} = '0;
    {n_ok, n_un, last_w, last_c, bad_count, check_count} = '0;
    en = 1'b1;
    void'($urandom(84155));
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    wb(0, `MORD_ADR_CTRL, 4'hF, 0, 32'h0000_0001);
    wb(0, `MORD_ADR_STAT, 4'hF, 0, 32'h0000_0000);
    wb(0, `MORD_ADR_LAST, 4'hF, 0, 32'h0000_0000);
    wb(0, `MORD_ADR_CTL, 4'hF, 0, 32'h0000_0000);
    wb(0, 8'h10, 4'hF, 0, 32'h0000_0000);
    $display("test reset done");
    foreach (tbl[i]) put(tbl[i], 0);
    drain("table");
    repeat (150) begin
      rnd = {`MORD_PFX, mm[$urandom_range(2)], 21'($urandom())};
      if ($urandom_range(9) == 0) rnd[31:25] = 7'h61;
      put(rnd, $urandom_range(1));
    end
    drain("random");
    wb(0, `MORD_ADR_STAT, 4'hF, 0, {n_un, n_ok});
    wb(0, `MORD_ADR_LAST, 4'hF, 0, last_w);
    wb(0, `MORD_ADR_CTL, 4'hF, 0, {7'h00, last_c});
    wb(1, `MORD_ADR_LAST, 4'hF, $urandom(), 0);
    wb(1, 8'h10, 4'hF, $urandom(), 0);
    wb(0, `MORD_ADR_LAST, 4'hF, 0, last_w);
    wb(0, 8'h10, 4'hF, 0, 32'h0000_0000);
    $display("test read only done");
    wb(1, `MORD_ADR_CTRL, 4'h1, 32'h0000_0000, 0);
    en = 1'b0;
    put(32'hC103_2800, 0);
    put(32'hC200_2000, 0);
    drain("disabled");
    // enable bit needs byte lane zero
    wb(1, `MORD_ADR_CTRL, 4'h2, 32'h0000_0001, 0);
    wb(0, `MORD_ADR_CTRL, 4'hF, 0, 32'h0000_0000);
    wb(0, `MORD_ADR_STAT, 4'hF, 0, {n_un, n_ok});
    wb(1, `MORD_ADR_CTRL, 4'h1, 32'h0000_0001, 0);
    en = 1'b1;
    wb(1, `MORD_ADR_STAT, 4'h8, 0, 0);
    wb(0, `MORD_ADR_STAT, 4'hF, 0, 32'h0000_0000);
    $display("test registers done");
    chk("wb pending", 0, wb_q.size());
    conclude();
  end
endmodule : tb_top
`default_nettype wire
